// *** logic/sprf_pkg.sv ***
// shared constants and types for the serial unit with power, reset and flag handling
package sprf_pkg;

    // byte and bit counts
    localparam int unsigned SPRF_W        = 8;
    localparam logic [2:0]  SPRF_LAST_BIT = 3'h7;
    localparam logic [2:0]  SPRF_FIRST    = 3'h0;

    // master baud divider terminal count: sck half period is this plus one ref clocks
    localparam logic [2:0]  SPRF_HALF_CYC = 3'h3;

    // control_reg_one write data field positions
    localparam int unsigned SPRF_C1_IRQ_EN = 7;
    localparam int unsigned SPRF_C1_SYS_EN = 6;
    localparam int unsigned SPRF_C1_MASTER = 4;
    localparam int unsigned SPRF_C1_SSOE   = 1;
    localparam int unsigned SPRF_C1_BIDIR  = 0;

    // port_direction_bits positions
    localparam int unsigned SPRF_DDR_MISO = 0;
    localparam int unsigned SPRF_DDR_MOSI = 1;
    localparam int unsigned SPRF_DDR_SCK  = 2;
    localparam int unsigned SPRF_DDR_SS   = 3;

    // reset values
    localparam logic [7:0]  SPRF_DATA_RST = 8'h00;
    localparam logic [3:0]  SPRF_DDR_RST  = 4'h0;

    // master engine states
    typedef enum logic [1:0] {
        SPRF_IDLE = 2'b01,
        SPRF_XFER = 2'b10
    } sprf_mst_type;

    // link-side slave shifter state
    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
    } sprf_shift_type;

    typedef struct packed {
        logic [7:0] rx;
        logic       tgl;
    } sprf_catch_type;

endpackage : sprf_pkg

// *** logic/sprf_link_if.sv ***
// signals between the core and the slave shifter on the link clock
`timescale 1ns/10ps
interface sprf_link_if;
    logic [7:0] tx_word;   // core domain, reloaded by any data write while the master engine is idle
    logic       din;       // serial input pin selected by bidirectional mode
    logic       dout;      // serial bit for the slave data output pin
    logic [7:0] rx_word;   // link domain, stable between toggles
    logic       rx_tgl;    // toggles once per received byte

    modport core  (output tx_word, output din, input dout, input rx_word, input rx_tgl);
    modport shift (input tx_word, input din, output dout, output rx_word, output rx_tgl);
endinterface : sprf_link_if

// *** logic/sprf_slave_shift.sv ***
// slave shift register clocked by the remote master's serial clock
`timescale 1ns/10ps
module sprf_slave_shift
    import sprf_pkg::*;
(
    input  wire logic        sck_i,
    input  wire logic        ss_b_i,
    input  wire logic        rst_b_i,
    sprf_link_if.shift       lk
);

    sprf_shift_type q;
    sprf_shift_type d;
    sprf_catch_type cq;
    sprf_catch_type cd;

    // sample on rising sck; keeps running in doze and stop while the master clocks
    always_comb begin
        d  = q;
        cd = cq;
        d.sh  = {q.sh[5:0], lk.din};
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == SPRF_LAST_BIT) begin
            cd.rx  = {q.sh, lk.din};
            cd.tgl = ~cq.tgl;
        end
    end

    // deselect restarts the bit count, so a late frame cannot stay misaligned
    always_ff @(posedge sck_i or posedge ss_b_i) begin
        if (ss_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // toggle survives deselect; only chip reset clears it so the core edge stays honest
    always_ff @(posedge sck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    // msb first; bit 7 is on the pin before the first edge
    assign lk.dout    = lk.tx_word[SPRF_LAST_BIT - q.cnt];
    assign lk.rx_word = cq.rx;
    assign lk.rx_tgl  = cq.tgl;

endmodule : sprf_slave_shift

// *** logic/sprf_core.sv ***
// serial unit core: master engine, flags, clear sequences, low-power and mode fault
// Function
// - bidirectional mode fault keeps the shared slave data pin direction bit
// - system enable clear stops serial clocks, registers stay accessible
// - doze with doze-stop select clear operates normally
// - doze with doze-stop select set stops the serial clock
// - master transfer freezes in clock-stopping doze and resumes after
// - slave keeps shifting on the remote clock during clock-stopping doze
// - in clock-stopping doze or stop no data register load and no done flag
// - chip stop behaves like doze with doze-stop select set
// - slave sends zero byte after reset before first data write
// - data register reads zero after reset until a transfer completes
// - done flag sets after eighth clock as byte enters data register
// - enabled done flag raises the interrupt request
// - while done flag is set new bytes are kept out
// - done flag clears by status read then data access, or reset
// - master with low slave select as fault input sets fault flag
// - enabled fault flag raises the interrupt request
// - fault clears system enable, master select and direction bits two to zero
// - fault flag clears by status read then control one write, or reset
// - slave select as output disables fault detection
`timescale 1ns/10ps
module sprf_core
    import sprf_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // cpu side register strobes
    input  wire logic       ctl1_wr_i,
    input  wire logic [7:0] ctl1_wdata_i,
    input  wire logic       doze_stop_select_i,
    input  wire logic       ddr_wr_i,
    input  wire logic [3:0] ddr_wdata_i,
    input  wire logic       data_wr_i,
    input  wire logic [7:0] data_wdata_i,
    input  wire logic       data_rd_i,
    input  wire logic       status_rd_i,
    input  wire logic       chip_doze_i,
    input  wire logic       chip_stop_i,
    output logic [7:0]      data_rdata_o,
    output logic            transfer_done_flag_o,
    output logic            mode_fault_flag_o,
    output logic            system_enable_bit_o,
    output logic            master_select_bit_o,
    output logic            interrupt_enable_bit_o,
    output logic [3:0]      port_direction_bits_o,
    output logic            irq_o,
    // serial link pins
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_b_o,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_b_o,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_b_o,
    input  wire logic       ss_b_i,
    output logic            ss_b_o,
    output logic            ss_oe_b_o
);

    // state legend, grouped by purpose:
    //   spe, master_select_bit, interrupt_enable_bit, ssoe, bidir - control_reg_one copy, writable while disabled
    //   ddr                          - port_direction_bits, 1 means output
    //   tx                           - byte offered to a remote master in slave mode
    //   rx                           - serial_data_register read view, zero after reset
    //   transfer_done_flag, mode_fault_flag                   - transfer_done_flag and mode_fault_flag
    //   transfer_done_flag_arm, mode_fault_flag_arm           - first half of each two-step clear sequence
    //   st, msh, bcnt, div, sck      - master engine, divider and shifter
    //   samp                         - master input bit caught at the rising edge
    //   ss_s*, mi_s*, mo_s*          - pin synchronisers, two stages each
    //   tg_s*                        - link toggle synchroniser plus edge stage
    //
    // limitations a user must know:
    //   baud is fixed at a half period of four reference clocks
    //   only clock phase zero with idle-low clock is supported
    //   a data write during a master byte is dropped, no collision flag
    //   clearing system enable or master select mid-byte abandons the byte
    //   the received byte crosses from the link clock by a toggle, so the
    //   word is stable long before the core edge stage sees the change
    //
    // trade-off: a clear armed before a new byte lands is withdrawn when
    // that byte sets the flag, so a stale status read cannot eat it

    // all core state in one record
    typedef struct packed {
        logic         system_enable_bit;
        logic         master_select_bit;
        logic         interrupt_enable_bit;
        logic         ssoe;
        logic         bidir;
        logic [3:0]   ddr;
        logic [7:0]   tx;
        logic [7:0]   rx;
        logic         transfer_done_flag;
        logic         mode_fault_flag;
        logic         transfer_done_flag_arm;
        logic         mode_fault_flag_arm;
        sprf_mst_type st;
        logic [7:0]   msh;
        logic [2:0]   bcnt;
        logic [2:0]   div;
        logic         sck;
        logic         samp;
        logic         ss_s1;
        logic         ss_s2;
        logic         mi_s1;
        logic         mi_s2;
        logic         mo_s1;
        logic         mo_s2;
        logic         tg_s1;
        logic         tg_s2;
        logic         tg_s3;
    } sprf_core_state_type;

    sprf_core_state_type q;
    sprf_core_state_type d;

    sprf_link_if lk ();

    logic       clk_stop;   // doze with select set, or chip stop
    logic       mdin;       // master serial input after synchronising
    logic       rx_new;
    logic [7:0] rx_byte;
    logic       ss_fault_in;

    // low-power decode: plain doze keeps running, select-set doze and stop freeze
    assign clk_stop = (chip_doze_i & doze_stop_select_i) | chip_stop_i;

    // bidirectional master listens on its own mosi pin
    assign mdin = q.bidir ? q.mo_s2 : q.mi_s2;

    // slave select acts as fault input only when not configured as any output
    assign ss_fault_in = ~(q.ssoe | q.ddr[SPRF_DDR_SS]);

    // link-side slave shifter; bidirectional slave receives on the shared miso pin
    assign lk.tx_word = q.tx;
    assign lk.din     = q.bidir ? miso_i : mosi_i;

    sprf_slave_shift u_shift (
        .sck_i   (sck_i),
        .ss_b_i  (ss_b_i),
        .rst_b_i (rst_b_i),
        .lk      (lk)
    );

    // next-state logic
    always_comb begin
        d       = q;
        rx_new  = 1'b0;
        rx_byte = SPRF_DATA_RST;

        // pin and toggle synchronisers; first stages feed only second stages
        d.ss_s1 = ss_b_i;
        d.ss_s2 = q.ss_s1;
        d.mi_s1 = miso_i;
        d.mi_s2 = q.mi_s1;
        d.mo_s1 = mosi_i;
        d.mo_s2 = q.mo_s1;
        d.tg_s1 = lk.rx_tgl;
        d.tg_s2 = q.tg_s1;
        d.tg_s3 = q.tg_s2;

        // first half of each clear sequence: status read while the flag is up
        if (status_rd_i && q.transfer_done_flag) begin
            d.transfer_done_flag_arm = 1'b1;
        end
        if (status_rd_i && q.mode_fault_flag) begin
            d.mode_fault_flag_arm = 1'b1;
        end

        // second half: data access clears done, control one write clears fault
        if ((data_rd_i || data_wr_i) && q.transfer_done_flag_arm) begin
            d.transfer_done_flag     = 1'b0;
            d.transfer_done_flag_arm = 1'b0;
        end
        if (ctl1_wr_i && q.mode_fault_flag_arm) begin
            d.mode_fault_flag     = 1'b0;
            d.mode_fault_flag_arm = 1'b0;
        end

        // register writes stay open even while disabled
        if (ctl1_wr_i) begin
            d.interrupt_enable_bit  = ctl1_wdata_i[SPRF_C1_IRQ_EN];
            d.system_enable_bit   = ctl1_wdata_i[SPRF_C1_SYS_EN];
            d.master_select_bit  = ctl1_wdata_i[SPRF_C1_MASTER];
            d.ssoe  = ctl1_wdata_i[SPRF_C1_SSOE];
            d.bidir = ctl1_wdata_i[SPRF_C1_BIDIR];
        end
        if (ddr_wr_i) begin
            d.ddr = ddr_wdata_i;
        end
        // a write during a master transfer is dropped to protect the shifting byte
        if (data_wr_i && (q.st == SPRF_IDLE)) begin
            d.tx = data_wdata_i;
        end

        // master engine
        unique case (q.st)
            SPRF_IDLE: begin
                d.sck  = 1'b0;
                d.div  = '0;
                d.bcnt = SPRF_FIRST;
                if (data_wr_i && q.system_enable_bit && q.master_select_bit && !clk_stop) begin
                    d.msh = data_wdata_i;
                    d.st  = SPRF_XFER;
                end
            end
            SPRF_XFER: begin
                if (!(q.system_enable_bit && q.master_select_bit)) begin
                    // disabled or demoted: abandon the byte, clocks stop
                    d.st  = SPRF_IDLE;
                    d.sck = 1'b0;
                end else if (!clk_stop) begin
                    // divider and shifter simply hold while clocks are stopped
                    d.div = q.div + 3'h1;
                    if (q.div == SPRF_HALF_CYC) begin
                        d.div = '0;
                        d.sck = ~q.sck;
                        if (!q.sck) begin
                            d.samp = mdin;
                        end else begin
                            d.msh  = {q.msh[6:0], q.samp};
                            d.bcnt = q.bcnt + 3'h1;
                            if (q.bcnt == SPRF_LAST_BIT) begin
                                d.st    = SPRF_IDLE;
                                rx_new  = 1'b1;
                                rx_byte = {q.msh[6:0], q.samp};
                            end
                        end
                    end
                end
            end
            default: begin
                d.st = SPRF_IDLE;
            end
        endcase

        // slave byte arrives from the link domain as a toggle edge
        if ((q.tg_s2 ^ q.tg_s3) && q.system_enable_bit && !q.master_select_bit) begin
            rx_new  = 1'b1;
            rx_byte = lk.rx_word;
        end

        // load data register; a same-cycle clear wins and the arriving byte is dropped
        if (rx_new && !clk_stop && !q.transfer_done_flag) begin
            d.rx       = rx_byte;
            d.transfer_done_flag     = 1'b1;
            d.transfer_done_flag_arm = 1'b0;
        end

        // mode fault wins over a control write in the same cycle
        if (q.master_select_bit && q.system_enable_bit && ss_fault_in && !q.ss_s2) begin
            d.mode_fault_flag               = 1'b1;
            d.mode_fault_flag_arm           = 1'b0;
            d.system_enable_bit                = 1'b0;
            d.master_select_bit               = 1'b0;
            d.ddr[SPRF_DDR_SCK]  = 1'b0;
            d.ddr[SPRF_DDR_MOSI] = 1'b0;
            if (!q.bidir) begin
                d.ddr[SPRF_DDR_MISO] = 1'b0;
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            q       <= '0;
            q.st    <= SPRF_IDLE;
            q.ddr   <= SPRF_DDR_RST;
            q.tx    <= SPRF_DATA_RST;
            q.rx    <= SPRF_DATA_RST;
            q.ss_s1 <= 1'b1;
            q.ss_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // register views
    assign data_rdata_o           = q.rx;
    assign transfer_done_flag_o   = q.transfer_done_flag;
    assign mode_fault_flag_o      = q.mode_fault_flag;
    assign system_enable_bit_o    = q.system_enable_bit;
    assign master_select_bit_o    = q.master_select_bit;
    assign interrupt_enable_bit_o = q.interrupt_enable_bit;
    assign port_direction_bits_o  = q.ddr;

    // single request from both enabled flags
    assign irq_o = q.interrupt_enable_bit & (q.transfer_done_flag | q.mode_fault_flag);

    // pin drivers; enables are low while driving
    assign sck_o       = q.sck;
    assign sck_oe_b_o  = ~(q.master_select_bit & q.ddr[SPRF_DDR_SCK]);
    assign mosi_o      = q.msh[7];
    assign mosi_oe_b_o = ~(q.master_select_bit & q.ddr[SPRF_DDR_MOSI]);
    assign miso_o      = lk.dout;
    assign miso_oe_b_o = ~(~q.master_select_bit & q.system_enable_bit & q.ddr[SPRF_DDR_MISO]);
    assign ss_b_o      = ~(q.ssoe & (q.st == SPRF_XFER));
    assign ss_oe_b_o   = ~(q.master_select_bit & q.ddr[SPRF_DDR_SS]);

endmodule : sprf_core

// *** sim/sprf_core_monitor.sv ***
// assertion checker for the serial unit core, bound to its ports
`timescale 1ns/10ps
module sprf_core_monitor
    import sprf_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic       ctl1_wr_i,
    input wire logic       data_wr_i,
    input wire logic       data_rd_i,
    input wire logic       status_rd_i,
    input wire logic       doze_stop_select_i,
    input wire logic       chip_doze_i,
    input wire logic       chip_stop_i,
    input wire logic [7:0] data_rdata_o,
    input wire logic       transfer_done_flag_o,
    input wire logic       mode_fault_flag_o,
    input wire logic       system_enable_bit_o,
    input wire logic       master_select_bit_o,
    input wire logic       interrupt_enable_bit_o,
    input wire logic [3:0] port_direction_bits_o,
    input wire logic       irq_o,
    input wire logic       sck_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // clear sequences: status read with the flag up, then the matching access
    sequence done_clr_s;
        transfer_done_flag_o && status_rd_i ##[1:8] (data_rd_i || data_wr_i);
    endsequence
    sequence fault_clr_s;
        mode_fault_flag_o && status_rd_i ##[1:8] ctl1_wr_i;
    endsequence
    // two samples of clock stop, so a frozen sck had an edge to move on
    sequence lp_stop_s;
        (chip_stop_i || (chip_doze_i && doze_stop_select_i)) [*2];
    endsequence

    irq_or_a: assert property (irq_o == (interrupt_enable_bit_o &&
        (transfer_done_flag_o || mode_fault_flag_o))) else $error("irq not gated flag or");
    done_clr_a: assert property (done_clr_s |=> !transfer_done_flag_o)
        else $error("done flag survived its clear");
    done_hold_a: assert property (transfer_done_flag_o && !data_rd_i && !data_wr_i
        |=> transfer_done_flag_o) else $error("done flag dropped unasked");
    data_lock_a: assert property (transfer_done_flag_o && $past(transfer_done_flag_o)
        |-> $stable(data_rdata_o)) else $error("data moved while done flag up");
    load_flag_a: assert property ($changed(data_rdata_o)
        |-> $rose(transfer_done_flag_o)) else $error("data loaded without done flag");
    lp_load_a: assert property ($rose(transfer_done_flag_o) |-> !$past(chip_stop_i)
        && !($past(chip_doze_i) && $past(doze_stop_select_i))) else $error("load in low power");
    lp_freeze_a: assert property (lp_stop_s |-> $stable(sck_o))
        else $error("serial clock ran in low power");
    off_still_a: assert property ((!system_enable_bit_o) [*2] |-> $stable(sck_o))
        else $error("serial clock ran while disabled");
    fault_cause_a: assert property ($rose(mode_fault_flag_o)
        |-> $past(master_select_bit_o) && $past(system_enable_bit_o)
        && !$past(port_direction_bits_o[3])) else $error("fault flag without master cause");
    fault_side_a: assert property ($rose(mode_fault_flag_o) |-> !system_enable_bit_o
        && !master_select_bit_o && port_direction_bits_o[2:1] == 2'h0)
        else $error("fault left controls set");
    fault_clr_a: assert property (fault_clr_s |=> !mode_fault_flag_o)
        else $error("fault flag survived its clear");
endmodule : sprf_core_monitor

bind sprf_core sprf_core_monitor mon (
    .ref_clk_i, .rst_b_i, .ctl1_wr_i, .data_wr_i, .data_rd_i, .status_rd_i,
    .doze_stop_select_i, .chip_doze_i, .chip_stop_i, .data_rdata_o, .transfer_done_flag_o,
    .mode_fault_flag_o, .system_enable_bit_o, .master_select_bit_o, .interrupt_enable_bit_o,
    .port_direction_bits_o, .irq_o, .sck_o
);

// *** sim/sprf_remote.sv ***
// remote serial party: a master with its own clock and a slave answering the core
`timescale 1ns/10ps
module sprf_remote (
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic ss_b,
    output logic      r_sck,
    output logic      r_mosi,
    output logic      r_miso,
    output logic      r_ss_b
);
    logic [7:0] slv, sh, got_m, got_s;
    initial begin
        r_sck = 1'b0;
        r_mosi = 1'b1;
        r_ss_b = 1'b1;
        slv = 8'h00;
        sh = 8'h00;
    end
    // slave side: loads on select, shifts on falling clock, captures on rising
    always @(negedge ss_b) sh <= slv;
    always @(negedge sck) sh <= {sh[6:0], ~sh[0]};
    always @(posedge sck) got_m <= {got_m[6:0], mosi};
    // deselected it shows the inverse bit, so a stale level never passes
    assign r_miso = ss_b ? ~sh[7] : sh[7];
    // master side: clock stands still outside the frame, sampled before rising
    task automatic frame(input logic [7:0] b);
        r_ss_b = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            r_mosi = b[i];
            #40;
            got_s = {got_s[6:0], miso};
            r_sck = 1'b1;
            #40;
            r_sck = 1'b0;
        end
        #40;
        r_ss_b = 1'b1;
        r_mosi = ~r_mosi;
    endtask : frame
endmodule : sprf_remote

// *** sim/testbench.sv ***
// self-checking bench for the serial unit core with a remote party
`timescale 1ns/10ps
module testbench;
    import sprf_pkg::*;
    localparam int SR = 0, DR = 1, DW = 2, DD = 3, C1 = 4;
    typedef struct packed { logic [7:0] tx; logic [7:0] rx; } sprf_row_type;
    logic ref_clk_i, rst_b_i, doze_stop_select_i, chip_doze_i, chip_stop_i, irq_o;
    logic transfer_done_flag_o, mode_fault_flag_o, system_enable_bit_o, master_select_bit_o;
    logic interrupt_enable_bit_o, sck_o, sck_oe_b_o, mosi_o, mosi_oe_b_o, miso_o, miso_oe_b_o;
    logic ss_b_o, ss_oe_b_o, r_sck, r_mosi, r_miso, r_ss_b;
    logic [7:0] wd, data_rdata_o;
    logic [4:0] stb;
    logic [3:0] port_direction_bits_o;
    logic [2:0] lp [3] = '{3'h4, 3'h6, 3'h1};
    sprf_row_type rows [3] = '{'{8'ha5, 8'h3c}, '{8'h00, 8'hff}, '{8'h81, 8'h7e}};
    int fails, n_compared, cyc;
    // pin levels: the core wins wherever its enable is low
    wire sck_w  = sck_oe_b_o ? r_sck : sck_o;
    wire mosi_w = mosi_oe_b_o ? r_mosi : mosi_o;
    wire miso_w = miso_oe_b_o ? r_miso : miso_o;
    wire ss_w   = ss_oe_b_o ? r_ss_b : ss_b_o;
    sprf_core dut (.ref_clk_i, .rst_b_i, .ctl1_wr_i(stb[C1]), .ctl1_wdata_i(wd),
        .doze_stop_select_i, .ddr_wr_i(stb[DD]), .ddr_wdata_i(wd[3:0]), .data_wr_i(stb[DW]),
        .data_wdata_i(wd), .data_rd_i(stb[DR]), .status_rd_i(stb[SR]), .chip_doze_i,
        .chip_stop_i, .data_rdata_o, .transfer_done_flag_o, .mode_fault_flag_o,
        .system_enable_bit_o, .master_select_bit_o, .interrupt_enable_bit_o,
        .port_direction_bits_o, .irq_o, .sck_i(sck_w), .sck_o, .sck_oe_b_o, .mosi_i(mosi_w),
        .mosi_o, .mosi_oe_b_o, .miso_i(miso_w), .miso_o, .miso_oe_b_o, .ss_b_i(ss_w), .ss_b_o,
        .ss_oe_b_o);
    sprf_remote rmt (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .ss_b(ss_w), .r_sck,
        .r_mosi, .r_miso, .r_ss_b);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one-cycle register strobe; returns just after the edge that took it
    task automatic st(input int k, input logic [7:0] v);
        @(posedge ref_clk_i);
        stb[k] <= 1'b1;
        wd <= v;
        @(posedge ref_clk_i);
        stb[k] <= 1'b0;
        #1;
    endtask : st
    task automatic wt(input int n);
        for (int i = 0; i < n && transfer_done_flag_o !== 1'b1; i++)
            @(posedge ref_clk_i);
        #1;
    endtask : wt
    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : pause
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // hang guard, well above the roughly 1400 cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        {rst_b_i, doze_stop_select_i, chip_doze_i, chip_stop_i, stb, wd} = '0;
        pause(2);
        rst_b_i = 1'b1;
        chk("reset data", 8'h00, data_rdata_o);
        chk("reset flags", 8'h00, {transfer_done_flag_o, mode_fault_flag_o, irq_o});
        st(C1, 8'hd2);
        st(DD, 8'h0e);
        foreach (rows[i]) begin
            rmt.slv = rows[i].rx;
            st(DW, rows[i].tx);
            wt(100);
            chk("rx byte", rows[i].rx, data_rdata_o);
            chk("tx byte", rows[i].tx, rmt.got_m);
            chk("done irq", 8'h01, irq_o);
            st(SR, 8'h00);
            st(DR, 8'h00);
            chk("done clear", 8'h00, {transfer_done_flag_o, irq_o});
        end
        st(DW, 8'h22);
        pause(100);
        rmt.slv = 8'h11;
        st(DW, 8'h44);
        pause(100);
        chk("locked data", 8'h7e, data_rdata_o);
        // mid-run reset with the done flag up, then restore master setup
        rst_b_i <= 1'b0;
        pause(2);
        rst_b_i <= 1'b1;
        chk("rerun data", 8'h00, data_rdata_o);
        chk("rerun done", 8'h00, {transfer_done_flag_o, irq_o});
        st(C1, 8'hd2);
        st(DD, 8'h0e);
        st(SR, 8'h00);
        st(DR, 8'h00);
        rmt.slv = 8'hc3;
        for (int m = 0; m < 3; m++) begin
            st(DW, 8'h5a);
            pause(10);
            {chip_doze_i, doze_stop_select_i, chip_stop_i} = lp[m];
            pause(120);
            chk("low power done", 8'(m == 0), transfer_done_flag_o);
            {chip_doze_i, doze_stop_select_i, chip_stop_i} = 3'h0;
            wt(100);
            chk("resumed data", 8'hc3, data_rdata_o);
            st(SR, 8'h00);
            st(DR, 8'h00);
        end
        st(C1, 8'hc0);
        st(DD, 8'h01);
        st(DW, 8'h96);
        foreach (rows[i]) begin
            chip_stop_i = (i == 1);
            rmt.frame(rows[i].rx);
            pause(2);
            chk("slave data", i == 1 ? 8'h3c : rows[i].rx, data_rdata_o);
            chk("slave done", 8'(i != 1), transfer_done_flag_o);
            chk("slave tx", 8'h96, rmt.got_s);
            chip_stop_i = 1'b0;
            st(SR, 8'h00);
            st(DR, 8'h00);
        end
        st(C1, 8'h50);
        st(DD, 8'h07);
        rmt.r_ss_b = 1'b0;
        pause(5);
        chk("fault set", 8'h02, {mode_fault_flag_o, irq_o});
        chk("fault ctl", 8'h00, {system_enable_bit_o, master_select_bit_o,
            port_direction_bits_o});
        st(C1, 8'hd0);
        pause(4);
        chk("fault kept", 8'h03, {mode_fault_flag_o, irq_o});
        rmt.r_ss_b = 1'b1;
        st(SR, 8'h00);
        st(C1, 8'hd1);
        chk("fault clear", 8'h00, mode_fault_flag_o);
        st(DD, 8'h07);
        rmt.r_ss_b = 1'b0;
        pause(5);
        chk("bidir ddr", 8'h01, port_direction_bits_o);
        rmt.r_ss_b = 1'b1;
        st(SR, 8'h00);
        st(C1, 8'h52);
        st(DD, 8'h07);
        rmt.r_ss_b = 1'b0;
        pause(5);
        chk("ss output no fault", 8'h00, mode_fault_flag_o);
        rmt.r_ss_b = 1'b1;
        st(C1, 8'h10);
        st(DD, 8'h05);
        st(DW, 8'h33);
        pause(100);
        chk("disabled", 8'h05, {transfer_done_flag_o, port_direction_bits_o});
        conclude();
    end
endmodule : testbench
